// File: dv/host_pins_model.sv
`timescale 1ns/1ps
// ***********************************************
// Host side model: request pins and event pulses
// ***********************************************
module host_pins_model (
  // Clock
  input  wire logic clk_sys_in,
  // Request levels
  output logic      system_domain_pin_out,
  output logic      power_domain_pin_out,
  output logic      level_wake_input_out,
  output logic      watchdog_enabled_out,
  output logic      external_reset_request_pin_n_out,
  // One-cycle event pulses
  output logic      power_button_short_out,
  output logic      internal_fault_out,
  output logic      watchdog_timeout_out
);
  // Quiet host at time zero; reset request released
  initial
  begin
    system_domain_pin_out            = 1'b0;
    power_domain_pin_out             = 1'b0;
    level_wake_input_out             = 1'b0;
    watchdog_enabled_out             = 1'b0;
    external_reset_request_pin_n_out = 1'b1;
    power_button_short_out           = 1'b0;
    internal_fault_out               = 1'b0;
    watchdog_timeout_out             = 1'b0;
  end

  // Levels change just after an edge and then stand
  task automatic set_levels(input logic sys, input logic pwr, input logic wdog);
    @(posedge clk_sys_in);
    system_domain_pin_out <= sys;
    power_domain_pin_out  <= pwr;
    watchdog_enabled_out  <= wdog;
  endtask : set_levels

  // Level wake and reset request levels change just after an edge
  task automatic set_wake_rst(input logic wake, input logic rst_n);
    @(posedge clk_sys_in);
    level_wake_input_out             <= wake;
    external_reset_request_pin_n_out <= rst_n;
  endtask : set_wake_rst

  // Pulse 0 short press, 1 internal fault, 2 watchdog timeout; exactly one cycle
  task automatic pulse(input int which);
    @(posedge clk_sys_in);
    power_button_short_out <= (which == 0);
    internal_fault_out     <= (which == 1);
    watchdog_timeout_out   <= (which == 2);
    @(posedge clk_sys_in);
    power_button_short_out <= 1'b0;
    internal_fault_out     <= 1'b0;
    watchdog_timeout_out   <= 1'b0;
  endtask : pulse
endmodule : host_pins_model

// File: dv/testbench.sv
`timescale 1ns/1ps
// ***********************************************
// Self-checking bench for the power mode sequencer
// ***********************************************
module testbench;
  import power_mode_sequencer_pkg::*;
  logic        clk_sys_in;
  logic        nrst_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        sys_pin, pwr_pin, wake_pin, wd_en, rst_req_n, press, fault, wd_to;
  logic        pread;
  logic        nvm_sys, nvm_pwr;  // Nonvolatile request presets
  logic [3:0]  reg_en, reg_b;
  logic        aux;
  logic [1:0]  mode;
  logic        irq_n;
  int          n_mismatch;
  int          check_count;
  int          pread_seen;   // Counts partial reload pulses
  logic [31:0] d;

  // 25 ns clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Pulse counter; the pulse stands one cycle only, so it is counted on the edge
  always @(posedge clk_sys_in)
  begin
    if (pread === 1'b1) pread_seen++;
  end

  host_pins_model i_host_pins_model (
    .clk_sys_in                       (clk_sys_in),
    .system_domain_pin_out            (sys_pin),
    .power_domain_pin_out             (pwr_pin),
    .level_wake_input_out             (wake_pin),
    .watchdog_enabled_out             (wd_en),
    .external_reset_request_pin_n_out (rst_req_n),
    .power_button_short_out           (press),
    .internal_fault_out               (fault),
    .watchdog_timeout_out             (wd_to)
  );

  // Delay codes 0 keep each slot at 1280 cycles, so a run stays short
  power_mode_sequencer #(.NREG(4)) i_power_mode_sequencer (
    .clk_sys_in                      (clk_sys_in),
    .nrst_in                         (nrst_in),
    .addr_in                         (addr_in),
    .wdata_in                        (wdata_in),
    .wr_in                           (wr_in),
    .rd_in                           (rd_in),
    .rdata_out                       (rdata_out),
    .system_domain_pin_in            (sys_pin),
    .power_domain_pin_in             (pwr_pin),
    .level_wake_input_in             (wake_pin),
    .power_button_short_in           (press),
    .external_reset_request_pin_n_in (rst_req_n),
    .internal_fault_in               (fault),
    .watchdog_timeout_in             (wd_to),
    .watchdog_enabled_in             (wd_en),
    .nvm_slot_delay_in               (8'h00),
    .nvm_empty_slot_delay_in         (8'h00),
    .nvm_system_preset_in            (nvm_sys),
    .nvm_power_preset_in             (nvm_pwr),
    .partial_nvm_read_out            (pread),
    .reg_enable_out                  (reg_en),
    .reg_b_select_out                (reg_b),
    .aux_function_out                (aux),
    .mode_out                        (mode),
    .interrupt_request_pin_n_out     (irq_n)
  );

  // ***********************************************
  // Bus and compare tasks
  // ***********************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
  endtask : rd

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: register value %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: output value %h, expected %h", $time, got, exp);
    end
  endtask : chk_pin

  // Bounded wait for a mode; running out counts as a mismatch and ends the run
  task automatic wait_mode(input mode_type m, input int bound);
    int i;
    // Look 1 ns after each edge, once the mode register has settled
    for (i = 0; i < bound && mode !== m; i++) @(posedge clk_sys_in) #1;
    chk_pin({6'h00, mode}, {6'h00, m});
    if (mode !== m) finish_test();
  endtask : wait_mode

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial
  begin
    int i;
    n_mismatch = 0;
    check_count = 0;
    pread_seen = 0;
    nrst_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    nvm_sys = 1'b0;
    nvm_pwr = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    // Reset values, unmapped address reads zero
    chk_pin({6'h00, mode}, 8'h01);
    chk_pin({7'h00, irq_n}, 8'h01);
    rd(CTRL_OFS, d);    chk_reg(d, 32'h0);
    rd(POINTER_OFS, d); chk_reg(d, 32'h3ff73);
    rd(TIMING_OFS, d);  chk_reg(d, 32'h0303);
    rd(REGSTEP_OFS, d); chk_reg(d, 32'h0);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, d);       chk_reg(d, 32'h0);
    // Last step 8; regs at 1, 5 (stay-on), 0, 9; aux pointer 0
    wr(POINTER_OFS, 32'h3f873);
    wr(REGSTEP_OFS, 32'h29051);
    // First stage with watchdog required and partial reload
    wr(CTRL_OFS, 32'h301);
    wait_mode(MODE_SYSTEM, 8000);
    rd(TIMING_OFS, d);  chk_reg(d, 32'h0);
    chk_pin(8'(pread_seen), 8'h01);
    chk_pin({4'h0, reg_en}, 8'h01);
    // Second stage runs but ACTIVE waits for the watchdog
    wr(CTRL_OFS, 32'h303);
    repeat (7000) @(posedge clk_sys_in);
    chk_pin({6'h00, mode}, {6'h00, MODE_SYSTEM});
    i_host_pins_model.set_levels(1'b0, 1'b0, 1'b1);
    wait_mode(MODE_ACTIVE, 50);
    chk_pin({4'h0, reg_en}, 8'h03);
    // Third stage up to last step raises the interrupt
    wr(CTRL_OFS, 32'h307);
    for (i = 0; i < 4000 && irq_n !== 1'b0; i++) @(posedge clk_sys_in);
    chk_pin({7'h00, irq_n}, 8'h00);
    rd(STATUS_OFS, d);  chk_reg({31'h0, d[ST_LAST_IRQ]}, 32'h1);
    wr(STATUS_OFS, 32'h100);
    @(posedge clk_sys_in);
    chk_pin({7'h00, irq_n}, 8'h01);
    chk_pin({3'h0, aux, reg_en}, 8'h03);
    // Power request removed: reverse to first end, stay-on reg to B
    wr(CTRL_OFS, 32'h301);
    wait_mode(MODE_SYSTEM, 8000);
    repeat (8000) @(posedge clk_sys_in);
    rd(STATUS_OFS, d);  chk_reg({27'h0, d[6:2]}, 32'h4);
    chk_pin({4'h0, reg_en}, 8'h03);
    chk_pin({4'h0, reg_b}, 8'h02);
    // Short press in ACTIVE runs down to POWERDOWN
    wr(CTRL_OFS, 32'h303);
    wait_mode(MODE_ACTIVE, 8000);
    i_host_pins_model.pulse(0);
    wait_mode(MODE_POWERDOWN, 12000);
    // Mode drops at once; the steps take eight slots to run down
    repeat (11000) @(posedge clk_sys_in);
    chk_pin({4'h0, reg_en}, 8'h02);
    wr(CTRL_OFS, 32'h0);
    // Freeze on the first watchdog timeout with retry limit 1, system pin stays high
    wr(POINTER_OFS, 32'h1f873);
    wr(CTRL_OFS, 32'h008);
    i_host_pins_model.set_levels(1'b1, 1'b0, 1'b1);
    wait_mode(MODE_SYSTEM, 8000);
    i_host_pins_model.pulse(2);
    wait_mode(MODE_POWERDOWN, 4);
    repeat (6000) @(posedge clk_sys_in);
    chk_pin({6'h00, mode}, {6'h00, MODE_POWERDOWN});
    rd(STATUS_OFS, d);  chk_reg({28'h0, d[15:12]}, 32'h0);
    i_host_pins_model.set_levels(1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    rd(STATUS_OFS, d);  chk_reg({28'h0, d[15:12]}, 32'h1);
    i_host_pins_model.set_levels(1'b1, 1'b0, 1'b1);
    wait_mode(MODE_SYSTEM, 8000);
    // Fast internal fault shutdown skips slot delays into RESET
    wr(CTRL_OFS, 32'h048);
    i_host_pins_model.set_levels(1'b0, 1'b0, 1'b1);
    i_host_pins_model.pulse(1);
    wait_mode(MODE_RESET, 40);
    chk_pin({4'h0, reg_en}, 8'h00);
    wait_mode(MODE_POWERDOWN, 40);
    // Level wake alone with no power request gives SYSTEM
    i_host_pins_model.set_wake_rst(1'b1, 1'b1);
    wait_mode(MODE_SYSTEM, 8000);
    // Falling reset request runs the slow shutdown and holds RESET
    i_host_pins_model.set_wake_rst(1'b1, 1'b0);
    wait_mode(MODE_RESET, 8000);
    chk_pin({4'h0, reg_en}, 8'h00);
    // Presets alone power up through both stages on release
    i_host_pins_model.set_wake_rst(1'b0, 1'b1);
    nvm_sys <= 1'b1;
    nvm_pwr <= 1'b1;
    wait_mode(MODE_ACTIVE, 12000);
    chk_pin({4'h0, reg_en}, 8'h03);
    finish_test();
  end
endmodule : testbench

// File: rtl/power_mode_sequencer.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// [R1] Leave ACTIVE when system request and level wake both drop, or on short press
// [R2] Watchdog timeouts count retries down, then freeze
// [R3] Next mode from power, system and wake inputs
// [R4] Freeze released when wakes drop or reset mode
// [R5] Freeze enable bit and programmable retry limit
// [R6] Shutdown runs power-down then enters reset mode
// [R7] Fast shutdown bits skip sequencer delays
// [R8] ACTIVE only after sequence and watchdog ready
// [R9] Sixteen steps, period 32 us to 8.192 ms
// [R10] Step up to last step, interrupt there
// [R11] Pointer beyond last step or aux at 0 ignored
// [R12] Stay-on regulators switch to B on power-down
// [R13] Slot delay, separate delay for empty slots
// [R14] Reload slot delays at each power-up start
// [R15] Optional partial reload, then first stage
// [R16] Wait after first stage for power request
// [R17] Second stage ends in ACTIVE with watchdog
// [R18] Software bit starts third stage up to last
// [R19] Steps beyond last step are disabled
// [R20] Reverse to first end, step 0, or jump on timeout
// [R21] Partial power-down stops at partial pointer
// [R22] Enable on the way up, disable on the way down
// [R23] Step 0 default supplies only with control set
module power_mode_sequencer
  import power_mode_sequencer_pkg::*;
#(
  parameter int NREG = 4
)(
  // Clock and reset
  input  wire logic            clk_sys_in,
  input  wire logic            nrst_in,
  // Register port
  input  wire logic [7:0]      addr_in,
  input  wire logic [31:0]     wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output logic      [31:0]     rdata_out,
  // Host pins and system events
  input  wire logic            system_domain_pin_in,
  input  wire logic            power_domain_pin_in,
  input  wire logic            level_wake_input_in,
  input  wire logic            power_button_short_in,
  input  wire logic            external_reset_request_pin_n_in,
  input  wire logic            internal_fault_in,
  input  wire logic            watchdog_timeout_in,
  input  wire logic            watchdog_enabled_in,
  // Nonvolatile memory values
  input  wire logic [7:0]      nvm_slot_delay_in,
  input  wire logic [7:0]      nvm_empty_slot_delay_in,
  input  wire logic            nvm_system_preset_in,
  input  wire logic            nvm_power_preset_in,
  output logic                 partial_nvm_read_out,
  // Controlled functions
  output logic [NREG-1:0]      reg_enable_out,
  output logic [NREG-1:0]      reg_b_select_out,
  output logic                 aux_function_out,
  output logic [1:0]           mode_out,
  output logic                 interrupt_request_pin_n_out
);

  // ****************************************
  // Registers and request terms
  // ****************************************
  logic [CTRL_W-1:0] ctrl_r;       // Control bits
  logic [19:0]       ptr_r;        // Stage pointers and retry limit
  logic [15:0]       timing_r;     // Slot and empty-slot delays
  logic [23:0]       regstep_r;    // Regulator pointers
  logic [4:0]        pos_r;        // Steps done; 0 means none
  logic [18:0]       tmr_r;        // Cycles spent in current slot
  logic [3:0]        retry_r;      // Remaining watchdog retries
  logic              irq_r;        // Last step reached, sticky
  logic              shut_r;       // Shutdown to reset pending
  logic              shut_fast_r;  // Shutdown skips delays
  logic              in_reset_r;   // Reset mode
  logic              btn_block_r;  // Short press forced power-down
  logic              reloaded_r;   // Power-up start handled
  logic              ext_prev_r;   // Previous reset request level
  logic [NREG-1:0]   reached_r;    // Stay-on regulator has been switched on
  mode_type          mode_r;       // Current power mode
  logic [31:0]       rdata_r;      // Read data
  logic              pread_r;      // Partial reload pulse

  wire [3:0] first_end  = ptr_r[FIRST_END_POS +: 4];
  wire [3:0] second_end = ptr_r[SECOND_END_POS +: 4];
  wire [3:0] last_step  = ptr_r[LAST_STEP_POS +: 4];
  wire [3:0] part_stop  = ptr_r[PART_STOP_POS +: 4];
  wire [3:0] aux_ptr    = regstep_r[AUX_POS +: 4];

  // Requests come from pin, register or preset
  wire sys_req = system_domain_pin_in | ctrl_r[SYSTEM_DOMAIN_PIN_BIT] | nvm_system_preset_in;
  wire pwr_req = power_domain_pin_in | ctrl_r[POWER_DOMAIN_PIN_BIT] | nvm_power_preset_in;
  wire wake    = (sys_req | level_wake_input_in) & ~btn_block_r;
  wire frozen  = ctrl_r[FREEZE_EN_BIT] & (retry_r == 4'h0);  // [R2] [R5]
  wire ext_fall = ext_prev_r & ~external_reset_request_pin_n_in;

  // Cap an end pointer at the last step
  function automatic logic [4:0] cap_pos(input logic [3:0] e, input logic [3:0] l);
    cap_pos = (e > l) ? {1'b0, l} + 5'h01 : {1'b0, e} + 5'h01;
  endfunction : cap_pos

  // Slot length in cycles for a delay code
  function automatic logic [18:0] slot_cycles(input logic [7:0] code);
    slot_cycles = 19'((code + 9'h001) * UNIT_CYCLES);
  endfunction : slot_cycles

  // ****************************************
  // Target position
  // ****************************************
  logic [4:0] floor_pos;
  logic [4:0] tgt_pos;
  // Where the sequencer heads for under present requests
  always_comb
  begin
    floor_pos = ctrl_r[STANDBY_BIT] ? {1'b0, part_stop} + 5'h01 : 5'h00;  // [R21]
    if (shut_r || in_reset_r)
      tgt_pos = 5'h00;  // [R6]
    else if (frozen || !wake)
      tgt_pos = floor_pos;  // [R2] [R3] [R20]
    else if (!pwr_req)
      tgt_pos = cap_pos(first_end, last_step);  // [R16] [R19] [R20]
    else if (!ctrl_r[THIRD_BIT])
      tgt_pos = cap_pos(second_end, last_step);  // [R17] [R19]
    else
      tgt_pos = {1'b0, last_step} + 5'h01;  // [R18]
  end

  // ****************************************
  // Slot timing
  // ****************************************
  logic       going_up;
  logic [3:0] slot_idx;
  logic       slot_used;
  logic [18:0] slot_len;
  logic       fast;
  logic       hold;
  // Select delay of the slot being entered or left
  always_comb
  begin
    going_up = tgt_pos > pos_r;
    slot_idx = going_up ? pos_r[3:0] : 4'(pos_r - 5'h01);
    slot_used = (aux_ptr == slot_idx);
    for (int i = 0; i < NREG; i++)
      slot_used = slot_used | (regstep_r[4*i +: 4] == slot_idx);
    // [R13]
    slot_len = slot_used ? slot_cycles(timing_r[SLOT_POS +: 8])
                         : slot_cycles(timing_r[EMPTY_POS +: 8]);
    fast = shut_r & shut_fast_r;  // [R7]
    // Stepping waits while a power-up start is still being handled
    hold = (pos_r == floor_pos) && going_up && !reloaded_r;
  end

  // Step counter and slot timer
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pos_r <= 5'h00;
      tmr_r <= 19'h00000;
    end
    else if (watchdog_timeout_in)
    begin
      pos_r <= 5'h00;  // [R20]
      tmr_r <= 19'h00000;
    end
    else if (pos_r == tgt_pos || hold)
      tmr_r <= 19'h00000;
    else if (fast || tmr_r >= slot_len - 19'h00001)
    begin
      // [R9] [R10] [R22]
      pos_r <= going_up ? pos_r + 5'h01 : pos_r - 5'h01;
      tmr_r <= 19'h00000;
    end
    else
      tmr_r <= tmr_r + 19'h00001;
  end

  // Power-up start: reload delays and partial read
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reloaded_r <= 1'b0;
      pread_r    <= 1'b0;
    end
    else
    begin
      pread_r <= hold & ctrl_r[RELOAD_EN_BIT];  // [R15]
      if (hold)
        reloaded_r <= 1'b1;
      else if (pos_r == floor_pos && tgt_pos == floor_pos)
        reloaded_r <= 1'b0;
    end
  end

  // ****************************************
  // Shutdown, reset mode and freeze
  // ****************************************
  // Shutdown requests, reset mode entry and exit
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      shut_r      <= 1'b0;
      shut_fast_r <= 1'b0;
      in_reset_r  <= 1'b0;
      ext_prev_r  <= 1'b1;
    end
    else
    begin
      ext_prev_r <= external_reset_request_pin_n_in;
      if (!shut_r && !in_reset_r && (internal_fault_in || ext_fall))
      begin
        shut_r      <= 1'b1;
        // [R7]
        shut_fast_r <= (internal_fault_in & ctrl_r[INT_FAST_BIT]) |
                       (ext_fall & ctrl_r[HOST_FAST_BIT]);
      end
      else if (shut_r && pos_r == 5'h00)
      begin
        shut_r     <= 1'b0;
        in_reset_r <= 1'b1;  // [R6]
      end
      else if (in_reset_r && external_reset_request_pin_n_in)
        in_reset_r <= 1'b0;
    end
  end

  // Retry counter with freeze release
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      retry_r <= POINTER_RST[RETRY_POS +: 4];
    else if (in_reset_r || (!level_wake_input_in && !sys_req))
      retry_r <= ptr_r[RETRY_POS +: 4];  // [R4] [R5]
    else if (watchdog_timeout_in && retry_r != 4'h0)
      retry_r <= retry_r - 4'h1;  // [R2]
  end

  // Short press in ACTIVE blocks wakes until they all drop
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      btn_block_r <= 1'b0;
    else if (power_button_short_in && mode_r == MODE_ACTIVE)
      btn_block_r <= 1'b1;  // [R1]
    else if (!sys_req && !level_wake_input_in)
      btn_block_r <= 1'b0;
  end

  // ****************************************
  // Mode and outputs
  // ****************************************
  // Mode follows the position reached
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mode_r <= MODE_POWERDOWN;
    else if (in_reset_r)
      mode_r <= MODE_RESET;
    else if (pos_r >= cap_pos(second_end, last_step) && pwr_req && wake &&
             (!ctrl_r[WD_USE_BIT] || watchdog_enabled_in))
      mode_r <= MODE_ACTIVE;  // [R3] [R8] [R17]
    else if (pos_r >= cap_pos(first_end, last_step) && wake)
      mode_r <= MODE_SYSTEM;  // [R3]
    else
      mode_r <= MODE_POWERDOWN;  // [R1] [R3]
  end

  logic [NREG-1:0] on_cond;
  logic            aux_cond;
  // Function enable from pointer and position
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
    begin
      if (regstep_r[4*i +: 4] > last_step)
        on_cond[i] = 1'b0;  // [R11]
      else if (regstep_r[4*i +: 4] == 4'h0)
        on_cond[i] = ctrl_r[DEFSUP_BIT] & ~in_reset_r;  // [R23]
      else
        on_cond[i] = pos_r > {1'b0, regstep_r[4*i +: 4]};  // [R22]
    end
    // Auxiliary pointer at zero disables the function
    aux_cond = (aux_ptr != 4'h0) && (aux_ptr <= last_step) &&
               (pos_r > {1'b0, aux_ptr});  // [R11]
  end

  // Regulator, B-select and function outputs
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reached_r        <= '0;
      reg_enable_out   <= '0;
      reg_b_select_out <= '0;
      aux_function_out <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NREG; i++)
      begin
        if (in_reset_r || !regstep_r[STAYON_POS + i])
          reached_r[i] <= 1'b0;
        else if (on_cond[i])
          reached_r[i] <= 1'b1;
      end
      // Stay-on regulators keep running on their B setting
      reg_enable_out   <= on_cond | (reached_r & ~{NREG{in_reset_r}});  // [R12]
      reg_b_select_out <= reached_r & ~on_cond & ~{NREG{in_reset_r}};  // [R12]
      aux_function_out <= aux_cond & ~in_reset_r;
    end
  end

  wire at_last = going_up && tgt_pos == {1'b0, last_step} + 5'h01 &&
                 pos_r == {1'b0, last_step} && (fast || tmr_r >= slot_len - 19'h00001);

  // Last-step flag; set beats a write-one clear
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      irq_r <= 1'b0;
    else if (at_last && !hold && !watchdog_timeout_in)
      irq_r <= 1'b1;  // [R10]
    else if (wr_in && addr_in == STATUS_OFS && wdata_in[ST_LAST_IRQ])
      irq_r <= 1'b0;
  end

  // ****************************************
  // Register port
  // ****************************************
  // Writes; power-up start reloads the delays over software
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_r    <= CTRL_RST;
      ptr_r     <= POINTER_RST;
      timing_r  <= TIMING_RST;
      regstep_r <= REGSTEP_RST;
    end
    else
    begin
      if (wr_in && addr_in == CTRL_OFS)
        ctrl_r <= wdata_in[CTRL_W-1:0];  // [R18]
      if (wr_in && addr_in == POINTER_OFS)
        ptr_r <= wdata_in[19:0];  // [R21]
      if (hold)
        timing_r <= {nvm_empty_slot_delay_in, nvm_slot_delay_in};  // [R14]
      else if (wr_in && addr_in == TIMING_OFS)
        timing_r <= wdata_in[15:0];
      if (wr_in && addr_in == REGSTEP_OFS)
        regstep_r <= wdata_in[23:0];
    end
  end

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_r <= 32'h00000000;
    else if (rd_in)
    begin
      unique case (addr_in)
        CTRL_OFS:    rdata_r <= {22'h000000, ctrl_r};
        POINTER_OFS: rdata_r <= {12'h000, ptr_r};
        TIMING_OFS:  rdata_r <= {16'h0000, timing_r};
        REGSTEP_OFS: rdata_r <= {8'h00, regstep_r};
        STATUS_OFS:  rdata_r <= {16'h0000, retry_r, 3'h0, irq_r, 1'b0,
                                 pos_r, mode_r};
        default:     rdata_r <= 32'h00000000;
      endcase
    end
    else
      rdata_r <= 32'h00000000;
  end

  assign rdata_out                   = rdata_r;
  assign mode_out                    = mode_r;
  assign partial_nvm_read_out        = pread_r;
  assign interrupt_request_pin_n_out = ~irq_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  wdog_jump_a: assert property (watchdog_timeout_in |=> pos_r == 5'h00) // [R20]
    else $error("watchdog did not return to step 0");
  retry_dec_a: assert property (watchdog_timeout_in && retry_r != 4'h0 && !in_reset_r &&
    (level_wake_input_in || sys_req) |=> retry_r == $past(retry_r) - 4'h1) // [R2]
    else $error("retry counter not decremented");
  freeze_hold_a: assert property (frozen && !shut_r && !in_reset_r |-> tgt_pos == floor_pos) // [R2]
    else $error("frozen but heading up");
  reset_enter_a: assert property (shut_r && pos_r == 5'h00 |=> ##1 mode_r == MODE_RESET) // [R6]
    else $error("shutdown did not reach reset mode");
  fast_step_a: assert property (fast && pos_r != tgt_pos && !hold &&
    !watchdog_timeout_in |=> pos_r != $past(pos_r)) // [R7]
    else $error("fast shutdown waited");
  active_gate_a: assert property (mode_r == MODE_ACTIVE && $past(ctrl_r[WD_USE_BIT])
    |-> $past(watchdog_enabled_in)) // [R8]
    else $error("active without watchdog");
  step_single_a: assert property (!watchdog_timeout_in && !$past(watchdog_timeout_in)
    |-> pos_r - $past(pos_r) inside {5'h00, 5'h01, 5'h1f}) // [R9]
    else $error("step skipped");
  irq_pin_a: assert property (at_last && !hold && !watchdog_timeout_in
    |=> !interrupt_request_pin_n_out) // [R10]
    else $error("last step interrupt missing");
  cap_last_a: assert property (pos_r <= {1'b0, last_step} + 5'h01 ||
    $changed(last_step) || $past(watchdog_timeout_in)) // [R19]
    else $error("position beyond last step");
  stay_b_a: assert property (reached_r != '0 && !in_reset_r |=>
    (reg_enable_out & $past(reached_r)) == $past(reached_r)) // [R12]
    else $error("stay-on regulator switched off");

  up_full_c: cover property (mode_r == MODE_SYSTEM ##[1:1000] mode_r == MODE_ACTIVE);
  freeze_c:  cover property (frozen && wake);
  shut_c:    cover property (shut_r ##[1:1000] in_reset_r);
  irq_c:     cover property ($fell(interrupt_request_pin_n_out));

endmodule : power_mode_sequencer

// File: rtl/power_mode_sequencer_pkg.sv
package power_mode_sequencer_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] POINTER_OFS  = 8'h04;
  localparam logic [7:0] TIMING_OFS   = 8'h08;
  localparam logic [7:0] REGSTEP_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  // Control register fields
  localparam int SYSTEM_DOMAIN_PIN_BIT    = 0;
  localparam int POWER_DOMAIN_PIN_BIT    = 1;
  localparam int THIRD_BIT     = 2;
  localparam int FREEZE_EN_BIT = 3;
  localparam int STANDBY_BIT   = 4;
  localparam int DEFSUP_BIT    = 5;
  localparam int INT_FAST_BIT  = 6;
  localparam int HOST_FAST_BIT = 7;
  localparam int WD_USE_BIT    = 8;
  localparam int RELOAD_EN_BIT = 9;
  localparam int CTRL_W        = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  // Pointer register fields, four bits each
  localparam int FIRST_END_POS  = 0;
  localparam int SECOND_END_POS = 4;
  localparam int LAST_STEP_POS  = 8;
  localparam int PART_STOP_POS  = 12;
  localparam int RETRY_POS      = 16;
  localparam logic [19:0] POINTER_RST = 20'h3ff73;
  // Timing register fields
  localparam int SLOT_POS  = 0;
  localparam int EMPTY_POS = 8;
  // Slot delay code 3 gives 128 us in 32 us units
  localparam logic [15:0] TIMING_RST = 16'h0303;
  // Regulator step pointers, stay-on bits, auxiliary pointer
  localparam int STAYON_POS = 16;
  localparam int AUX_POS    = 20;
  localparam logic [23:0] REGSTEP_RST = 24'h000000;
  // Status register fields
  localparam int ST_STEP_POS  = 2;
  localparam int ST_FROZEN    = 7;
  localparam int ST_LAST_IRQ  = 8;
  localparam int ST_RETRY_POS = 12;
  // Timing
  localparam int CLK_MHZ     = 40;
  localparam int UNIT_US     = 32;
  localparam int UNIT_CYCLES = UNIT_US * CLK_MHZ;
  localparam int STEPS       = 16;
  // Power modes
  typedef enum logic [1:0] {MODE_RESET, MODE_POWERDOWN, MODE_SYSTEM, MODE_ACTIVE} mode_type;
endpackage : power_mode_sequencer_pkg
